// file: flash_array_model.sv
// Behavioural flash array on the controller's word port
module flash_array_model
(
   // Clock
   input  logic        clk_sys,
   // Word port
   input  logic [14:0] fl_addr,
   input  logic        fl_we,
   input  logic [31:0] fl_wdata,
   output logic [31:0] fl_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:32767];
   // Array starts blank
   initial foreach (mem[i]) mem[i] = 32'hFFFF_FFFF;
   // Word store of the value the controller merged
   always @(posedge clk_sys) if (fl_we) mem[fl_addr] <= fl_wdata;
   // Word read follows the address at once
   assign fl_rdata = mem[fl_addr];
endmodule // flash_array_model

// file: flash_prot_regs.vh
// Offsets, field positions, reset values and timing for the flash guard
// Behaviour
// - Flash erases in 1 KB pages; erase leaves every page bit at one.
// - Word program acts on one 32-bit word and only clears bits.
// - Protection unit is 2 KB, two pages, one program and one read bit.
// - Protection bits live in two program words and two read words.
// - Program bit one allows write and erase; zero refuses any change.
// - Read bit zero allows only instruction fetch, no data reads.
// - Both bits zero: execute-only, no write, erase or data read.
// - Program one, read zero: write, erase, fetch allowed; data read refused.
// - Program zero, read one: read-only; reads and fetches, no change.
// - Both bits one: unprotected, every access allowed.
// - Execute-only contents reach only the fetch path, never data reads.
// - Data read of a read-protected unit is blocked with a bus fault.
// - Change of program-protected unit is blocked; interrupt only if masked in.
// - Factory state of every protection bit is one.
// - Software only clears protection bits; power-on restores uncommitted ones.
// - Commit through the control register makes current bits permanent.
// - Program and erase timing counts from software cycles-per-microsecond.
// - Microsecond reload resets to suit top clock; software reloads MHz-1.
// - Commit starts on commit key write with target code in address reg.
// - Writing one to masked status clear drops raw and masked flags.
`ifndef FLASH_PROT_REGS_VH
`define FLASH_PROT_REGS_VH

// Register byte offsets
`define OFS_TARGET_ADDR  12'h000
`define OFS_WRITE_DATA   12'h004
`define OFS_CONTROL      12'h008
`define OFS_RAW_STATUS   12'h00C
`define OFS_IRQ_MASK     12'h010
`define OFS_MASKED_CLR   12'h014
`define OFS_USEC_RELOAD  12'h140
`define OFS_READ_EN0     12'h200
`define OFS_READ_EN1     12'h204
`define OFS_PROG_EN0     12'h400
`define OFS_PROG_EN1     12'h404

// Control register fields
`define CTL_KEY          16'hA442
`define CTL_WRITE_BIT    0
`define CTL_ERASE_BIT    1
`define CTL_COMMIT_BIT   3

// Commit target codes in the address register
`define CODE_READ_EN0    32'h0000_0000
`define CODE_PROG_EN0    32'h0000_0001
`define CODE_READ_EN1    32'h0000_0002
`define CODE_PROG_EN1    32'h0000_0003

// Status and mask bit positions
`define IRQ_ACCESS_BIT   0
`define IRQ_PROG_BIT     1

// Reset values
`define USEC_RESET       8'h13
`define PROT_RESET       32'hFFFF_FFFF

// Operation times in microseconds
`define PROG_TIME_US     8'h14
`define ERASE_WORD_US    8'h01
`define COMMIT_TIME_US   8'h32

// AXI responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// file: flash_protect_timing_ctrl.v
// Flash controller with block protection, commit and microsecond timing
//
// Design decisions made here: the AXI4-Lite register port and the address map.
module flash_protect_timing_ctrl
(
   // Clock and resets
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        por_restore,
   input  wire        factory_blank,
   // AXI4-Lite write address and data
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Processor flash read port
   input  wire        cpu_req,
   input  wire [16:0] cpu_addr,
   input  wire        cpu_fetch,
   output wire        cpu_ready,
   output reg         cpu_rvalid,
   output reg  [31:0] cpu_rdata,
   output reg         cpu_fault,
   // Flash array word port
   output reg  [14:0] fl_addr,
   output reg         fl_we,
   output reg  [31:0] fl_wdata,
   input  wire [31:0] fl_rdata,
   // Interrupt
   output wire        irq
);

`include "flash_prot_regs.vh"

// One-hot operation states
localparam [4:0] S_IDLE   = 5'h01;
localparam [4:0] S_PREAD  = 5'h02;
localparam [4:0] S_WAIT   = 5'h04;
localparam [4:0] S_NEXT   = 5'h08;
localparam [4:0] S_COMMIT = 5'h10;

reg  [4:0]  state_q;
reg  [31:0] target_q;
reg  [31:0] wdata_reg_q;
reg  [3:0]  ctl_busy_q;
reg  [1:0]  raw_q;
reg  [1:0]  mask_q;
reg  [7:0]  usec_q;
reg  [7:0]  us_cnt_q;
reg  [7:0]  wait_q;
reg         erasing_q;
reg         rd_pend_q;
reg         rd_fetch_q;
reg  [11:0] awaddr_q;
reg         aw_got_q;
reg  [31:0] wd_q;
reg  [3:0]  ws_q;
reg         w_got_q;
reg  [31:0] rd_mux;
reg         rd_hit;
reg         wr_hit;
reg         set_access;
reg         set_prog;
reg  [3:0]  commit_sel;

wire [31:0] read_en0;
wire [31:0] read_en1;
wire [31:0] prog_en0;
wire [31:0] prog_en1;

//////////////////////////////////////////////////////////////////////////
// Byte-lane merge for partial writes
function [31:0] merge;
   input [31:0] old;
   input [31:0] nw;
   input [3:0]  strb;
   integer i;
   begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
         if (strb[i])
            merge[i*8 +: 8] = nw[i*8 +: 8];
   end
endfunction

//////////////////////////////////////////////////////////////////////////
// AXI write channel capture
wire wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
wire [31:0] wr_val = merge(32'hFFFF_FFFF, wd_q, ws_q);
assign s_axi_awready = ~aw_got_q;
assign s_axi_wready  = ~w_got_q;

// Address and data accepted in either order
always @(posedge clk_sys)
begin
   if (reset)
   begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 12'h000;
      wd_q     <= 32'h0000_0000;
      ws_q     <= 4'h0;
   end
   else
   begin
      if (s_axi_awvalid && !aw_got_q)
      begin
         aw_got_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
         aw_got_q <= 1'b0;
      if (s_axi_wvalid && !w_got_q)
      begin
         w_got_q <= 1'b1;
         wd_q    <= s_axi_wdata;
         ws_q    <= s_axi_wstrb;
      end
      else if (wr_fire)
         w_got_q <= 1'b0;
   end
end

// Write address decode
always @*
begin
   case (awaddr_q)
      `OFS_TARGET_ADDR, `OFS_WRITE_DATA, `OFS_CONTROL, `OFS_RAW_STATUS,
      `OFS_IRQ_MASK, `OFS_MASKED_CLR, `OFS_USEC_RELOAD, `OFS_READ_EN0,
      `OFS_READ_EN1, `OFS_PROG_EN0, `OFS_PROG_EN1:
         wr_hit = 1'b1;
      default:
         wr_hit = 1'b0;
   endcase
end

// Write response
always @(posedge clk_sys)
begin
   if (reset)
   begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
   end
   else if (wr_fire)
   begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
   end
   else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
end

wire wr_tgt   = wr_fire && (awaddr_q == `OFS_TARGET_ADDR);
wire wr_wdat  = wr_fire && (awaddr_q == `OFS_WRITE_DATA);
wire wr_ctl   = wr_fire && (awaddr_q == `OFS_CONTROL);
wire wr_mask  = wr_fire && (awaddr_q == `OFS_IRQ_MASK);
wire wr_clr   = wr_fire && (awaddr_q == `OFS_MASKED_CLR);
wire wr_usec  = wr_fire && (awaddr_q == `OFS_USEC_RELOAD);
wire key_ok   = (wd_q[31:16] == `CTL_KEY) && (ws_q == 4'hF);
wire idle     = state_q[0];
wire [31:0] mask_new = merge({30'h0, mask_q}, wd_q, ws_q);
wire [31:0] usec_new = merge({24'h0, usec_q}, wd_q, ws_q);

//////////////////////////////////////////////////////////////////////////
// Plain software registers
always @(posedge clk_sys)
begin
   if (reset)
   begin
      target_q    <= 32'h0000_0000;
      wdata_reg_q <= 32'h0000_0000;
      mask_q      <= 2'h0;
      usec_q      <= `USEC_RESET;
   end
   else
   begin
      if (wr_tgt && idle)
         target_q <= merge(target_q, wd_q, ws_q);
      if (wr_wdat && idle)
         wdata_reg_q <= merge(wdata_reg_q, wd_q, ws_q);
      if (wr_mask)
         mask_q <= mask_new[1:0];
      if (wr_usec)
         usec_q <= usec_new[7:0];
   end
end

//////////////////////////////////////////////////////////////////////////
// Protection words, one bit per 2 KB unit, 64 units
wire pwr_re0 = wr_fire && (awaddr_q == `OFS_READ_EN0);
wire pwr_re1 = wr_fire && (awaddr_q == `OFS_READ_EN1);
wire pwr_pe0 = wr_fire && (awaddr_q == `OFS_PROG_EN0);
wire pwr_pe1 = wr_fire && (awaddr_q == `OFS_PROG_EN1);

prot_word u_read_en0
(
   .clk_sys       (clk_sys),
   .reset         (reset),
   .factory_blank (factory_blank),
   .por_restore   (por_restore),
   .wr_en         (pwr_re0),
   .wr_data       (wr_val),
   .commit        (commit_sel[0]),
   .cur_q         (read_en0)
);

prot_word u_prog_en0
(
   .clk_sys       (clk_sys),
   .reset         (reset),
   .factory_blank (factory_blank),
   .por_restore   (por_restore),
   .wr_en         (pwr_pe0),
   .wr_data       (wr_val),
   .commit        (commit_sel[1]),
   .cur_q         (prog_en0)
);

prot_word u_read_en1
(
   .clk_sys       (clk_sys),
   .reset         (reset),
   .factory_blank (factory_blank),
   .por_restore   (por_restore),
   .wr_en         (pwr_re1),
   .wr_data       (wr_val),
   .commit        (commit_sel[2]),
   .cur_q         (read_en1)
);

prot_word u_prog_en1
(
   .clk_sys       (clk_sys),
   .reset         (reset),
   .factory_blank (factory_blank),
   .por_restore   (por_restore),
   .wr_en         (pwr_pe1),
   .wr_data       (wr_val),
   .commit        (commit_sel[3]),
   .cur_q         (prog_en1)
);

// Unit lookups: target unit for changes, read unit for the array port
wire [63:0] prog_map = {prog_en1, prog_en0};
wire [63:0] read_map = {read_en1, read_en0};
wire        tgt_prog_ok = prog_map[target_q[16:11]];
wire        rd_read_ok  = read_map[fl_addr[14:9]];

//////////////////////////////////////////////////////////////////////////
// Microsecond tick from software reload value
wire us_tick = (us_cnt_q == 8'h00);

always @(posedge clk_sys)
begin
   if (reset)
      us_cnt_q <= `USEC_RESET;
   else if (us_tick || wr_usec)
      us_cnt_q <= usec_q;
   else
      us_cnt_q <= us_cnt_q - 8'h01;
end

//////////////////////////////////////////////////////////////////////////
// Program, erase and commit sequencer
wire start_wr  = wr_ctl && idle && key_ok && wd_q[`CTL_WRITE_BIT];
wire start_er  = wr_ctl && idle && key_ok && wd_q[`CTL_ERASE_BIT];
wire start_cm  = wr_ctl && idle && key_ok && wd_q[`CTL_COMMIT_BIT];
wire cpu_take  = cpu_req && cpu_ready;
assign cpu_ready = idle && !rd_pend_q && !start_wr && !start_er && !start_cm;

always @(posedge clk_sys)
begin
   if (reset)
   begin
      state_q    <= S_IDLE;
      ctl_busy_q <= 4'h0;
      fl_addr    <= 15'h0000;
      fl_we      <= 1'b0;
      fl_wdata   <= 32'h0000_0000;
      wait_q     <= 8'h00;
      erasing_q  <= 1'b0;
      set_access <= 1'b0;
      set_prog   <= 1'b0;
      commit_sel <= 4'h0;
   end
   else
   begin
      set_access <= 1'b0;
      set_prog   <= 1'b0;
      commit_sel <= 4'h0;
      fl_we      <= 1'b0;
      case (state_q)
         S_IDLE:
         begin
            if ((start_wr || start_er) && !tgt_prog_ok)
               set_access <= 1'b1;
            else if (start_wr)
            begin
               ctl_busy_q[`CTL_WRITE_BIT] <= 1'b1;
               fl_addr   <= target_q[16:2];
               erasing_q <= 1'b0;
               state_q   <= S_PREAD;
            end
            else if (start_er)
            begin
               ctl_busy_q[`CTL_ERASE_BIT] <= 1'b1;
               fl_addr   <= {target_q[16:10], 8'h00};
               fl_wdata  <= 32'hFFFF_FFFF;
               wait_q    <= `ERASE_WORD_US;
               erasing_q <= 1'b1;
               state_q   <= S_WAIT;
            end
            else if (start_cm)
            begin
               ctl_busy_q[`CTL_COMMIT_BIT] <= 1'b1;
               wait_q  <= `COMMIT_TIME_US;
               state_q <= S_COMMIT;
            end
            else if (cpu_take)
               fl_addr <= cpu_addr[16:2];
         end
         S_PREAD:
         begin
            fl_wdata <= fl_rdata & wdata_reg_q;
            wait_q   <= `PROG_TIME_US;
            state_q  <= S_WAIT;
         end
         S_WAIT:
         begin
            if (us_tick && wait_q == 8'h00)
            begin
               fl_we   <= 1'b1;
               state_q <= S_NEXT;
            end
            else if (us_tick)
               wait_q <= wait_q - 8'h01;
         end
         S_NEXT:
         begin
            if (erasing_q && fl_addr[7:0] != 8'hFF)
            begin
               fl_addr <= fl_addr + 15'h0001;
               wait_q  <= `ERASE_WORD_US;
               state_q <= S_WAIT;
            end
            else
            begin
               ctl_busy_q <= 4'h0;
               set_prog   <= 1'b1;
               state_q    <= S_IDLE;
            end
         end
         S_COMMIT:
         begin
            if (us_tick && wait_q == 8'h00)
            begin
               commit_sel[0] <= (target_q == `CODE_READ_EN0);
               commit_sel[1] <= (target_q == `CODE_PROG_EN0);
               commit_sel[2] <= (target_q == `CODE_READ_EN1);
               commit_sel[3] <= (target_q == `CODE_PROG_EN1);
               ctl_busy_q    <= 4'h0;
               state_q       <= S_IDLE;
            end
            else if (us_tick)
               wait_q <= wait_q - 8'h01;
         end
         default:
            state_q <= S_IDLE;
      endcase
   end
end

//////////////////////////////////////////////////////////////////////////
// Processor reads: fetch always served, data reads need read enable
always @(posedge clk_sys)
begin
   if (reset)
   begin
      rd_pend_q  <= 1'b0;
      rd_fetch_q <= 1'b0;
      cpu_rvalid <= 1'b0;
      cpu_rdata  <= 32'h0000_0000;
      cpu_fault  <= 1'b0;
   end
   else
   begin
      rd_pend_q  <= cpu_take;
      cpu_rvalid <= rd_pend_q;
      if (cpu_take)
         rd_fetch_q <= cpu_fetch;
      if (rd_pend_q && (rd_fetch_q || rd_read_ok))
      begin
         cpu_rdata <= fl_rdata;
         cpu_fault <= 1'b0;
      end
      else if (rd_pend_q)
      begin
         cpu_rdata <= 32'h0000_0000;
         cpu_fault <= 1'b1;
      end
   end
end

//////////////////////////////////////////////////////////////////////////
// Sticky status, set wins over clear
always @(posedge clk_sys)
begin
   if (reset)
      raw_q <= 2'h0;
   else
   begin
      if (wr_clr && ws_q[0])
         raw_q <= raw_q & ~wd_q[1:0];
      if (set_access)
         raw_q[`IRQ_ACCESS_BIT] <= 1'b1;
      if (set_prog)
         raw_q[`IRQ_PROG_BIT] <= 1'b1;
   end
end

assign irq = |(raw_q & mask_q);

//////////////////////////////////////////////////////////////////////////
// AXI read channel
assign s_axi_arready = ~s_axi_rvalid;

always @*
begin
   rd_hit = 1'b1;
   case (s_axi_araddr)
      `OFS_TARGET_ADDR: rd_mux = target_q;
      `OFS_WRITE_DATA:  rd_mux = wdata_reg_q;
      `OFS_CONTROL:     rd_mux = {28'h0, ctl_busy_q};
      `OFS_RAW_STATUS:  rd_mux = {30'h0, raw_q};
      `OFS_IRQ_MASK:    rd_mux = {30'h0, mask_q};
      `OFS_MASKED_CLR:  rd_mux = {30'h0, raw_q & mask_q};
      `OFS_USEC_RELOAD: rd_mux = {24'h0, usec_q};
      `OFS_READ_EN0:    rd_mux = read_en0;
      `OFS_READ_EN1:    rd_mux = read_en1;
      `OFS_PROG_EN0:    rd_mux = prog_en0;
      `OFS_PROG_EN1:    rd_mux = prog_en1;
      default:
      begin
         rd_mux = 32'h0000_0000;
         rd_hit = 1'b0;
      end
   endcase
end

// Read data registered one cycle after address
always @(posedge clk_sys)
begin
   if (reset)
   begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
   end
   else if (s_axi_arvalid && !s_axi_rvalid)
   begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
   end
   else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
end

endmodule // flash_protect_timing_ctrl

// file: flash_protect_timing_ctrl_assertions.sv
// Port checker for the flash guard
module flash_protect_timing_ctrl_assertions
(
   // Clock and reset
   input logic        clk_sys,
   input logic        reset,
   // Register bus
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   // Processor read port
   input logic        cpu_req,
   input logic        cpu_fetch,
   input logic        cpu_ready,
   input logic        cpu_rvalid,
   input logic [31:0] cpu_rdata,
   input logic        cpu_fault,
   // Array port and interrupt
   input logic        fl_we,
   input logic [31:0] fl_wdata,
   input logic [31:0] fl_rdata,
   input logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   property p_cpu_answer;
      cpu_req && cpu_ready |-> ##2 cpu_rvalid;
   endproperty
   a_cpu_answer: assert property (p_cpu_answer)
      else $error("processor answer late");
   property p_fetch_ok;
      cpu_req && cpu_ready && cpu_fetch |-> ##2 cpu_rvalid && !cpu_fault;
   endproperty
   a_fetch_ok: assert property (p_fetch_ok)
      else $error("fetch faulted");
   property p_fault_blank;
      cpu_rvalid && cpu_fault |-> cpu_rdata == 32'h0000_0000;
   endproperty
   a_fault_blank: assert property (p_fault_blank)
      else $error("faulted read leaked data");
   property p_clear_only;
      fl_we |-> ((fl_wdata & ~fl_rdata) == 32'h0) || (&fl_wdata);
   endproperty
   a_clear_only: assert property (p_clear_only)
      else $error("array write set a bit");
   property p_held_off;
      fl_we |-> !cpu_ready;
   endproperty
   a_held_off: assert property (p_held_off)
      else $error("read taken during array write");
   property p_b_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer)
      else $error("write response late");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_r_answer: assert property (p_r_answer)
      else $error("read response late");
   property p_quiet;
      $fell(reset) |-> !irq && !fl_we && !cpu_rvalid && !s_axi_bvalid;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("outputs active after reset");
   // Main scenarios
   c_fault: cover property (cpu_rvalid && cpu_fault);
   c_write: cover property (fl_we);
   c_irq: cover property ($rose(irq));
endmodule // flash_protect_timing_ctrl_assertions

// file: flash_protect_timing_ctrl_tb.sv
// Self-checking bench for the flash guard
`include "flash_prot_regs.vh"
`define CHK(got, exp) \
   begin \
      checked++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("Error at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module flash_protect_timing_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, reset, por_restore, factory_blank;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, cpu_rdata, fl_wdata, fl_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, cpu_req, cpu_fetch, cpu_ready;
   logic        cpu_rvalid, cpu_fault, fl_we, irq, cf;
   logic [16:0] cpu_addr;
   logic [14:0] fl_addr;
   logic [31:0] rd, cd;
   int          err_total, checked;
   flash_protect_timing_ctrl i_dut (.clk_sys, .reset, .por_restore,
      .factory_blank, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .cpu_req, .cpu_addr, .cpu_fetch,
      .cpu_ready, .cpu_rvalid, .cpu_rdata, .cpu_fault, .fl_addr, .fl_we,
      .fl_wdata, .fl_rdata, .irq);
   flash_array_model i_flash (.clk_sys, .fl_addr, .fl_we, .fl_wdata,
      .fl_rdata);
   ////////////////////////////////////////////////////////////////////////
   // Bus cycles
   task wr(input logic [11:0] a, input logic [31:0] d);
      begin
         @(posedge clk_sys);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do
         begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end
         while (s_axi_bvalid !== 1'b1);
         rsp = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask
   task rdr(input logic [11:0] a);
      begin
         @(posedge clk_sys);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do
         begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end
         while (s_axi_rvalid !== 1'b1);
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   task wait_idle;
      int n;
      begin
         n = 0;
         do
         begin
            rdr(`OFS_CONTROL);
            n++;
         end
         while (rd[3:0] != 4'h0 && n < 1000);
         `CHK(rd[3:0], 4'h0)
      end
   endtask
   task cpu_rd(input logic [16:0] a, input logic f);
      begin
         @(posedge clk_sys);
         cpu_addr <= a;
         cpu_fetch <= f;
         cpu_req <= 1'b1;
         do
            @(posedge clk_sys);
         while (cpu_ready !== 1'b1);
         cpu_req <= 1'b0;
         repeat (2) @(posedge clk_sys);
         `CHK(cpu_rvalid, 1'b1)
         cd = cpu_rdata;
         cf = cpu_fault;
      end
   endtask
   task op(input logic [11:0] t, input logic [31:0] d, input logic [1:0] c);
      begin
         wr(`OFS_WRITE_DATA, d);
         wr(`OFS_TARGET_ADDR, {20'h0, t});
         wr(`OFS_CONTROL, {`CTL_KEY, 14'h0, c});
         wait_idle;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task t_reset_values;
      logic [11:0] ofs [4];
      begin
         ofs = '{`OFS_READ_EN0, `OFS_READ_EN1, `OFS_PROG_EN0, `OFS_PROG_EN1};
         foreach (ofs[i])
         begin
            rdr(ofs[i]);
            `CHK(rd, `PROT_RESET)
         end
         rdr(`OFS_USEC_RELOAD);
         `CHK(rd[7:0], `USEC_RESET)
         rdr(12'hFFC);
         `CHK(rsp, `RESP_SLVERR)
         wr(12'hFF0, 32'h0000_0000);
         `CHK(rsp, `RESP_SLVERR)
         $display("test reset_values done");
      end
   endtask
   task t_program;
      begin
         wr(`OFS_USEC_RELOAD, 32'h0000_0001);
         wr(`OFS_IRQ_MASK, 32'h0000_0002);
         op(12'h104, 32'hF0F0_F0F0, 2'h1);
         `CHK(irq, 1'b1)
         op(12'h104, 32'h0FF0_0FFF, 2'h1);
         cpu_rd(17'h00104, 1'b0);
         `CHK(cd, 32'h00F0_00F0)
         rdr(`OFS_RAW_STATUS);
         `CHK(rd[1:0], 2'b10)
         wr(`OFS_MASKED_CLR, 32'h0000_0002);
         rdr(`OFS_RAW_STATUS);
         `CHK(rd[1:0], 2'b00)
         `CHK(irq, 1'b0)
         $display("test program done");
      end
   endtask
   task t_erase;
      begin
         op(12'h400, 32'h0000_0000, 2'h1);
         op(12'h100, 32'h0000_0000, 2'h2);
         cpu_rd(17'h00104, 1'b1);
         `CHK(cd, 32'hFFFF_FFFF)
         cpu_rd(17'h003FC, 1'b0);
         `CHK(cd, 32'hFFFF_FFFF)
         cpu_rd(17'h00400, 1'b0);
         `CHK(cd, 32'h0000_0000)
         $display("test erase done");
      end
   endtask
   task t_prog_protect;
      begin
         wr(`OFS_PROG_EN0, 32'hFFFF_FFFE);
         wr(`OFS_PROG_EN0, 32'hFFFF_FFFF);
         rdr(`OFS_PROG_EN0);
         `CHK(rd, 32'hFFFF_FFFE)
         wr(`OFS_IRQ_MASK, 32'h0000_0001);
         op(12'h000, 32'h0000_0000, 2'h1);
         `CHK(irq, 1'b1)
         cpu_rd(17'h00000, 1'b0);
         `CHK(cd, 32'hFFFF_FFFF)
         `CHK(cf, 1'b0)
         wr(`OFS_MASKED_CLR, 32'h0000_0001);
         wr(`OFS_IRQ_MASK, 32'h0000_0000);
         op(12'h400, 32'h0000_0000, 2'h2);
         rdr(`OFS_RAW_STATUS);
         `CHK(rd[0], 1'b1)
         `CHK(irq, 1'b0)
         cpu_rd(17'h00400, 1'b0);
         `CHK(cd, 32'h0000_0000)
         wr(`OFS_MASKED_CLR, 32'h0000_0001);
         $display("test prog_protect done");
      end
   endtask
   task t_read_protect;
      begin
         wr(`OFS_READ_EN0, 32'hFFFF_FFFC);
         cpu_rd(17'h00400, 1'b0);
         `CHK({cf, cd}, {1'b1, 32'h0})
         cpu_rd(17'h00400, 1'b1);
         `CHK({cf, cd}, {1'b0, 32'h0})
         op(12'h800, 32'h5A5A_5A5A, 2'h1);
         cpu_rd(17'h00800, 1'b0);
         `CHK({cf, cd}, {1'b1, 32'h0})
         cpu_rd(17'h00800, 1'b1);
         `CHK({cf, cd}, {1'b0, 32'h5A5A_5A5A})
         $display("test read_protect done");
      end
   endtask
   task t_commit;
      begin
         wr(`OFS_TARGET_ADDR, `CODE_PROG_EN0);
         wr(`OFS_CONTROL, {`CTL_KEY, 16'h0008});
         wait_idle;
         @(posedge clk_sys);
         por_restore <= 1'b1;
         @(posedge clk_sys);
         por_restore <= 1'b0;
         rdr(`OFS_PROG_EN0);
         `CHK(rd, 32'hFFFF_FFFE)
         rdr(`OFS_READ_EN0);
         `CHK(rd, 32'hFFFF_FFFF)
         $display("test commit done");
      end
   endtask
   task close_out;
      begin
         $display("checked %0d mismatches %0d", checked, err_total);
         if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Watchdog
   initial
   begin
      #2_000_000;
      err_total++;
      close_out;
   end
   // Main sequence
   initial
   begin
      {err_total, checked} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, cpu_req, cpu_fetch} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, cpu_addr} = '0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      por_restore = 1'b0;
      factory_blank = 1'b1;
      reset = 1'b1;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      factory_blank <= 1'b0;
      t_reset_values;
      t_program;
      t_erase;
      t_prog_protect;
      t_read_protect;
      t_commit;
      close_out;
   end
endmodule // flash_protect_timing_ctrl_tb
bind flash_protect_timing_ctrl flash_protect_timing_ctrl_assertions i_chk (
   .clk_sys, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .cpu_req, .cpu_fetch, .cpu_ready, .cpu_rvalid,
   .cpu_rdata, .cpu_fault, .fl_we, .fl_wdata, .fl_rdata, .irq);

// file: prot_word.v
// One protection word: working copy and committed copy
module prot_word
(
   // Clock and reset
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        factory_blank,
   input  wire        por_restore,
   // Software access
   input  wire        wr_en,
   input  wire [31:0] wr_data,
   input  wire        commit,
   // State
   output reg  [31:0] cur_q
);

`include "flash_prot_regs.vh"

reg [31:0] nv_q;

// Committed copy, survives everything but factory blanking
always @(posedge clk_sys)
begin
   if (factory_blank)
      nv_q <= `PROT_RESET;
   else if (commit)
      nv_q <= cur_q;
end

// Working copy: clears only, power-on falls back to committed copy
always @(posedge clk_sys)
begin
   if (factory_blank)
      cur_q <= `PROT_RESET;
   else if (reset || por_restore)
      cur_q <= nv_q;
   else if (wr_en)
      cur_q <= cur_q & wr_data;
end

endmodule // prot_word
